// ---- core/smsp_pkg.sv ----
// package: constants, configuration carrier and state enum for the serial port
package smsp_pkg;
   localparam int         DATA_W         = 16;        // widest character
   localparam int         FIFO_DEPTH     = 16;        // words per fifo
   localparam int         PTR_W          = 4;         // fifo pointer width
   localparam int         CNT_W          = 9;         // timing counter width
   localparam int         SYNC_W         = 4;         // synchronised pins
   localparam int         SYN_SCLK       = 0;         // sync slot: serial clock
   localparam int         SYN_STE        = 1;         // sync slot: slave select (low)
   localparam int         SYN_SIMO       = 2;         // sync slot: master-out data
   localparam int         SYN_SOMI       = 3;         // sync slot: master-in data
   localparam int         ST_OVERRUN     = 0;         // status bit: receive overrun
   localparam int         ST_BUSY        = 1;         // status bit: word in flight
   localparam int         ST_TX_FULL     = 2;         // status bit: transmit side full
   localparam int         ST_RX_AVAIL    = 3;         // status bit: receive word waiting
   localparam logic [6:0] DIV_DIRECT_MIN = 7'h03;     // below this the clock is fixed
   localparam logic [7:0] PERIOD_FLOOR   = 8'h04;     // fixed period in peripheral clocks
   localparam logic [8:0] SEL_LEAD_TRIM  = 9'h003;    // system clocks cut from select lead
   localparam logic [4:0] DEPTH_ENH      = 5'h10;     // fifo limit, enhancement on
   localparam logic [4:0] DEPTH_BYPASS   = 5'h01;     // single-word buffer limit
   localparam logic [7:0] UPPER_BYTE     = 8'h00;     // upper status byte reads zero
   localparam logic [15:0] WORD_RST      = 16'h0000;  // shift and buffer reset value
   localparam logic [15:0] WORD_ONES     = 16'hFFFF;  // receive mask seed

   typedef struct packed {
      logic       master;        // operation_control master bit
      logic       phase;         // operation_control clock phase bit
      logic       polarity;      // character_config_control clock polarity
      logic       fifo_enh;      // fifo_enhance_enable
      logic [3:0] char_len;      // character length minus one
      logic [6:0] divider;       // bit_rate_divider
   } smsp_cfg_s;

   typedef enum logic [1:0] {SM_IDLE, SM_LEAD, SM_SHIFT, SM_TRAIL} smsp_state_e;
endpackage

// ---- core/smsp_port.sv ----
// serial port engine: master/slave shifter, clock divider and two word fifos
// Notes on behaviour
// - status reads low byte, upper byte zero
// - sixteen-word transmit and receive fifos
// - enhancement off bypasses fifos, single word
// - only master makes clock; slave follows
// - drive one edge, sample the opposite
// - phase set advances bits half cycle
// - full duplex: word out, word in
// - master bit set drives clock, select
// - period four, or divider plus one
// - polarity picks idle level and edges
// - software keeps serial clock under limits
// - even divider: longer half per phase
// - select leads first edge by set time
// - select released half period after end
// - master bit clear: clock, select inputs
// - character length one to sixteen bits
// - polarity and phase give four schemes
// - four lines: clock, two data, select
`timescale 1ns/1ps
module smsp_port (
   input  wire logic                 CLK_SYS,                   // system clock, 250 MHz
   input  wire logic                 RST_B,                     // async reset, low
   input  wire smsp_pkg::smsp_cfg_s  CFG,                       // mode and timing setup
   input  wire logic                 TX_VALID,                  // transmit word offered
   output logic                      TX_READY,                  // transmit side has room
   input  wire logic [15:0]          TX_DATA,                   // transmit word, msb first
   output logic                      RX_VALID,                  // received word waiting
   input  wire logic                 RX_READY,                  // consumer takes word
   output logic [15:0]               RX_DATA,                   // received word, right aligned
   input  wire logic                 OVR_CLR,                   // clears overrun flag
   output logic [15:0]               STATUS,                    // status word
   input  wire logic                 SERIAL_CLOCK_LINE_I,       // clock pin level
   output logic                      SERIAL_CLOCK_LINE_O,       // clock pin drive
   output logic                      SERIAL_CLOCK_LINE_OE,      // clock pin enable
   input  wire logic                 SLAVE_SELECT_LINE_N_I,     // select pin level
   output logic                      SLAVE_SELECT_LINE_N_O,     // select pin drive
   output logic                      SLAVE_SELECT_LINE_N_OE,    // select pin enable
   input  wire logic                 MASTER_OUT_DATA_LINE_I,    // master-out pin level
   output logic                      MASTER_OUT_DATA_LINE_O,    // master-out pin drive
   output logic                      MASTER_OUT_DATA_LINE_OE,   // master-out pin enable
   input  wire logic                 MASTER_IN_DATA_LINE_I,     // master-in pin level
   output logic                      MASTER_IN_DATA_LINE_O,     // master-in pin drive
   output logic                      MASTER_IN_DATA_LINE_OE     // master-in pin enable
);
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RST_B);

   logic [1:0]  push, pop, full, empty;
   logic [15:0] din [2];
   logic [15:0] dout [2];
   logic [4:0]  fcnt [2];

   // two word fifos: slot 0 transmit, slot 1 receive
   genvar g;
   generate
      for (g = 0; g < 2; g++)
      begin : g_fifo
         logic [15:0] mem_q [smsp_pkg::FIFO_DEPTH];
         logic [15:0] mem_d [smsp_pkg::FIFO_DEPTH];
         logic [3:0]  wp_q, wp_d, rp_q, rp_d;
         logic [4:0]  cnt_q, cnt_d;
         always_comb
         begin
            mem_d = mem_q;
            wp_d  = wp_q;
            rp_d  = rp_q;
            if (push[g])
            begin
               mem_d[wp_q] = din[g];
               wp_d        = wp_q + 4'h1;
            end
            if (pop[g])
               rp_d = rp_q + 4'h1;
            cnt_d = cnt_q + {4'h0, push[g]} - {4'h0, pop[g]};
         end
         always_ff @(posedge CLK_SYS or negedge RST_B)
         begin
            if (!RST_B)
            begin
               for (int i = 0; i < smsp_pkg::FIFO_DEPTH; i++)
                  mem_q[i] <= smsp_pkg::WORD_RST;
               wp_q  <= 4'h0;
               rp_q  <= 4'h0;
               cnt_q <= 5'h00;
            end
            else
            begin
               mem_q <= mem_d;
               wp_q  <= wp_d;
               rp_q  <= rp_d;
               cnt_q <= cnt_d;
            end
         end
         // limit collapses to one word when enhancement is off
         assign full[g]  = cnt_q >= (CFG.fifo_enh ? smsp_pkg::DEPTH_ENH
                                                  : smsp_pkg::DEPTH_BYPASS);
         assign empty[g] = cnt_q == 5'h00;
         assign dout[g]  = mem_q[rp_q];
         assign fcnt[g]  = cnt_q;
      end
   endgenerate

   // pin synchronisers: change counts once stages two and three agree
   logic [3:0] s1_q, s2_q, s3_q, f_q, f_d, pin_in;
   assign pin_in = {MASTER_IN_DATA_LINE_I, MASTER_OUT_DATA_LINE_I,
                    SLAVE_SELECT_LINE_N_I, SERIAL_CLOCK_LINE_I};
   assign f_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & f_q);
   always_ff @(posedge CLK_SYS or negedge RST_B)
   begin
      if (!RST_B)
      begin
         s1_q <= 4'h2;
         s2_q <= 4'h2;
         s3_q <= 4'h2;
         f_q  <= 4'h2;
      end
      else
      begin
         s1_q <= pin_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         f_q  <= f_d;
      end
   end

   // divider, half periods and select lead
   logic [7:0] per;
   logic [7:0] h_long, h_short;
   logic [8:0] lead_len;
   logic [15:0] rx_mask;
   assign per      = (CFG.divider < smsp_pkg::DIV_DIRECT_MIN) ? smsp_pkg::PERIOD_FLOOR
                     : {1'b0, CFG.divider} + 8'h01;
   assign h_long   = 8'((9'(per) + 9'h001) >> 1);
   assign h_short  = per >> 1;
   assign lead_len = CFG.phase ? {per, 1'b0} - smsp_pkg::SEL_LEAD_TRIM
                     : 9'(per) + 9'(h_short) - smsp_pkg::SEL_LEAD_TRIM;
   assign rx_mask  = smsp_pkg::WORD_ONES >> (4'hF - CFG.char_len);

   // shift engine state
   smsp_pkg::smsp_state_e state_q, state_d;
   logic [8:0]  cnt_q, cnt_d;
   logic [4:0]  edge_q, edge_d;
   logic [15:0] sh_q, sh_d;
   logic        out_q, out_d, sclk_q, sclk_d, ste_q, ste_d, done_q, done_d;
   logic        ovr_q, ovr_d, sclkp_q, selp_q, act_q, act_d;
   logic        sel, ev, last, smp, drv, in_bit, load_s, tx_pop;

   assign sel    = ~CFG.master & ~f_q[smsp_pkg::SYN_STE];
   assign ev     = CFG.master ? (state_q == smsp_pkg::SM_SHIFT && cnt_q == 9'h000)
                  : (sel & (f_q[smsp_pkg::SYN_SCLK] ^ sclkp_q));
   assign last   = edge_q == {CFG.char_len, 1'b1};
   assign smp    = ev & (edge_q[0] == CFG.phase);
   assign drv    = ev & (edge_q[0] != CFG.phase);
   assign in_bit = CFG.master ? f_q[smsp_pkg::SYN_SOMI] : f_q[smsp_pkg::SYN_SIMO];
   assign load_s = sel & (~selp_q | done_q) & ~empty[0];

   // next-state logic for the shifter and master sequencer
   always_comb
   begin
      state_d = state_q;
      cnt_d   = cnt_q;
      edge_d  = edge_q;
      sh_d    = sh_q;
      out_d   = out_q;
      sclk_d  = sclk_q;
      ste_d   = ste_q;
      done_d  = 1'b0;
      tx_pop  = 1'b0;
      act_d   = sel;
      if (ev)
      begin
         edge_d = last ? 5'h00 : edge_q + 5'h01;
         done_d = last;
         if (smp)
            sh_d = {sh_q[14:0], in_bit};
         if (drv)
            out_d = sh_q[15];
      end
      if (!CFG.master && !sel)
         edge_d = 5'h00;
      if (load_s)
      begin
         tx_pop = 1'b1;
         sh_d   = dout[0];
         out_d  = dout[0][15];
      end
      case (state_q)
         smsp_pkg::SM_IDLE:
         begin
            sclk_d = CFG.polarity;
            ste_d  = 1'b0;
            if (CFG.master && !empty[0])
            begin
               tx_pop  = 1'b1;
               sh_d    = dout[0];
               out_d   = dout[0][15];
               ste_d   = 1'b1;
               edge_d  = 5'h00;
               cnt_d   = lead_len - 9'h002;
               state_d = smsp_pkg::SM_LEAD;
            end
         end
         smsp_pkg::SM_LEAD:
         begin
            cnt_d = (cnt_q == 9'h000) ? 9'h000 : cnt_q - 9'h001;
            if (cnt_q == 9'h000)
               state_d = smsp_pkg::SM_SHIFT;
         end
         smsp_pkg::SM_SHIFT:
         begin
            cnt_d = cnt_q - 9'h001;
            if (ev)
            begin
               sclk_d = ~sclk_q;
               cnt_d  = 9'((edge_q[0] ^ CFG.phase) ? h_short : h_long) - 9'h001;
               if (last)
               begin
                  cnt_d   = 9'(h_long) - 9'h001;
                  state_d = smsp_pkg::SM_TRAIL;
               end
            end
         end
         smsp_pkg::SM_TRAIL:
         begin
            cnt_d = cnt_q - 9'h001;
            if (cnt_q == 9'h000)
            begin
               ste_d   = 1'b0;
               state_d = smsp_pkg::SM_IDLE;
            end
         end
         default:
            state_d = smsp_pkg::SM_IDLE;
      endcase
      ovr_d = (done_q & full[1]) | (ovr_q & ~OVR_CLR);
   end

   // engine registers
   always_ff @(posedge CLK_SYS or negedge RST_B)
   begin
      if (!RST_B)
      begin
         state_q <= smsp_pkg::SM_IDLE;
         cnt_q   <= 9'h000;
         edge_q  <= 5'h00;
         sh_q    <= smsp_pkg::WORD_RST;
         out_q   <= 1'b0;
         sclk_q  <= 1'b0;
         ste_q   <= 1'b0;
         done_q  <= 1'b0;
         ovr_q   <= 1'b0;
         sclkp_q <= 1'b0;
         selp_q  <= 1'b0;
         act_q   <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         edge_q  <= edge_d;
         sh_q    <= sh_d;
         out_q   <= out_d;
         sclk_q  <= sclk_d;
         ste_q   <= ste_d;
         done_q  <= done_d;
         ovr_q   <= ovr_d;
         sclkp_q <= f_q[smsp_pkg::SYN_SCLK];
         selp_q  <= sel;
         act_q   <= act_d;
      end
   end

   // fifo hookup: finished word goes to the receive side
   assign push[0]  = TX_VALID & ~full[0];
   assign TX_READY = ~full[0];
   assign din[0]   = TX_DATA;
   assign push[1]  = done_q & ~full[1];
   assign din[1]   = sh_q & rx_mask;
   assign pop      = {RX_READY & ~empty[1], tx_pop};
   assign RX_VALID = ~empty[1];
   assign RX_DATA  = dout[1];

   // pin drive: master owns clock, select, master-out; slave owns master-in
   assign SERIAL_CLOCK_LINE_O     = sclk_q;
   assign SERIAL_CLOCK_LINE_OE    = CFG.master;
   assign SLAVE_SELECT_LINE_N_O   = ~ste_q;
   assign SLAVE_SELECT_LINE_N_OE  = CFG.master;
   assign MASTER_OUT_DATA_LINE_O  = out_q;
   assign MASTER_OUT_DATA_LINE_OE = CFG.master;
   assign MASTER_IN_DATA_LINE_O   = out_q;
   assign MASTER_IN_DATA_LINE_OE  = ~CFG.master & act_q;

   // status word, upper byte fixed at zero
   assign STATUS = {smsp_pkg::UPPER_BYTE, 4'h0, RX_VALID, full[0],
                    (state_q != smsp_pkg::SM_IDLE) | (act_q & (edge_q != 5'h00)),
                    ovr_q};

   // helper: cycles since select went active in master mode
   logic [8:0] gap_q;
   always_ff @(posedge CLK_SYS or negedge RST_B)
   begin
      if (!RST_B)
         gap_q <= 9'h000;
      else
         gap_q <= (state_q == smsp_pkg::SM_IDLE) ? 9'h000 : gap_q + 9'h001;
   end

   sequence last_edge_s;
      CFG.master && ev && last && state_q == smsp_pkg::SM_SHIFT;
   endsequence
   sequence select_held_s;
      ste_q ##1 ste_q;
   endsequence

   chk_upper_zero: assert property (STATUS[15:8] == 8'h00)
      else $error("status upper byte not zero");
   chk_fifo_depth: assert property (fcnt[1] <= 5'h10)
      else $error("receive fifo above sixteen words");
   chk_bypass_one: assert property (!CFG.fifo_enh && !empty[0] |-> !TX_READY)
      else $error("bypass buffer accepted a second word");
   chk_slave_clock: assert property (!CFG.master |-> !SERIAL_CLOCK_LINE_OE
                                      && !SLAVE_SELECT_LINE_N_OE)
      else $error("slave drives clock or select");
   chk_select_lead: assert property (CFG.master && $changed(sclk_q)
         && $past(state_q) == smsp_pkg::SM_SHIFT && $past(edge_q) == 5'h00
         |-> gap_q == lead_len)
      else $error("select lead time wrong");
   chk_select_tail: assert property (last_edge_s |=> select_held_s)
      else $error("select released too early");
   chk_idle_level: assert property (CFG.master && state_q == smsp_pkg::SM_IDLE
                                    |=> sclk_q == $past(CFG.polarity))
      else $error("idle clock level wrong");
   chk_half_min: assert property (CFG.master && $changed(sclk_q) |=> $stable(sclk_q))
      else $error("serial clock half shorter than two cycles");
   chk_rx_push: assert property (done_q && !full[1] |=> RX_VALID)
      else $error("finished word not stored");
   chk_slave_quiet: assert property (!CFG.master && !sel |=> !MASTER_IN_DATA_LINE_OE)
      else $error("deselected slave drives data");
endmodule

// ---- verification/smsp_peer.sv ----
// peer model: far-side serial device acting as slave or master
`timescale 1ns/1ps
module smsp_peer (
   input  wire logic       clk,        // system clock
   input  wire logic       act_master, // peer drives clock and select
   input  wire logic       phase,      // clock phase setting
   input  wire logic       polarity,   // idle clock level
   input  wire logic [4:0] len,        // bits per word
   input  wire logic       sclk_i,     // clock line level
   input  wire logic       sel_n_i,    // select line level
   input  wire logic       mosi_i,     // master-out line level
   input  wire logic       miso_i,     // master-in line level
   output logic            sclk_o,     // clock drive
   output logic            sel_n_o,    // select drive
   output logic            dat_o,      // data drive, line by role
   output logic            miso_oe     // master-in enable
);
   logic [15:0] tx_word; // word the peer sends
   logic [15:0] rx_word; // word the peer took
   logic        sck;     // clock state, zero when idle
   int          edg;     // edges in this frame
   int          nsamp;   // bits sampled in this frame

   // idle clock rests at the polarity level; slave drives only when selected
   assign sclk_o = sck ^ polarity;
   assign miso_oe = !act_master && !sel_n_i;

   // one edge: sample on one parity, drive the next bit on the other
   task automatic step(input logic din);
      if (edg[0] == phase)
      begin
         rx_word = {rx_word[14:0], din};
         nsamp++;
      end
      else if (nsamp < len)
         dat_o = tx_word[len - 1 - nsamp];
      edg++;
   endtask

   // frame start puts the first bit out before any edge
   task automatic frame_start();
      edg = 0;
      nsamp = 0;
      rx_word = 16'h0000;
      dat_o = tx_word[len - 1];
   endtask

   // slave role follows the master's edges while selected
   always @(negedge sel_n_i)
      if (!act_master)
         frame_start();
   always @(sclk_i)
      if (!act_master && !sel_n_i)
         step(mosi_i);

   // master role: select, lead, 2*len half-cycle edges, trail
   task automatic run_master(input logic sel, input int half);
      @(negedge clk);
      sel_n_o = !sel;
      frame_start();
      repeat (2 * half) @(negedge clk);
      repeat (2 * len)
      begin
         sck = !sck;
         step(miso_i);
         repeat (half) @(negedge clk);
      end
      sel_n_o = 1'b1;
   endtask

   initial
   begin
      sck = 1'b0;
      sel_n_o = 1'b1;
      dat_o = 1'b0;
      tx_word = 16'h0000;
      rx_word = 16'h0000;
   end
endmodule

// ---- verification/tb.sv ----
// testbench: serial port engine against the peer model in both roles
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin error_cnt++; \
   $display("ERROR %s expected %0h seen %0h", nm, ex, gt); end end
`define WAIT(c) begin wt = 0; while ((c) !== 1'b1 && wt < 9000) begin @(negedge clk_sys); \
   wt++; end if (wt >= 9000) begin error_cnt++; print_verdict(); end end
module tb;
   logic                clk_sys, rst_b, tx_valid, tx_ready, rx_valid, rx_ready, ovr_clr;
   smsp_pkg::smsp_cfg_s cfg;                      // port setup
   logic [15:0]         tx_data, rx_data, status; // data and status
   logic                d_sck, d_sck_oe, d_sel, d_sel_oe, d_mo, d_mo_oe, d_mi, d_mi_oe;
   logic                p_sck, p_sel, p_dat, p_mi_oe, peer_m;
   logic                sck, sel, mo, mi, mo_f, mi_f; // resolved lines
   int                  error_cnt, comparisons, wt, cyc, n_edge, t_lo, t_hi;
   int                  t_e[0:31];                // edge times in a frame

   smsp_port u_dut (
      .CLK_SYS(clk_sys), .RST_B(rst_b), .CFG(cfg), .TX_VALID(tx_valid), .TX_READY(tx_ready),
      .TX_DATA(tx_data), .RX_VALID(rx_valid), .RX_READY(rx_ready), .RX_DATA(rx_data),
      .OVR_CLR(ovr_clr), .STATUS(status), .SERIAL_CLOCK_LINE_I(sck),
      .SERIAL_CLOCK_LINE_O(d_sck), .SERIAL_CLOCK_LINE_OE(d_sck_oe),
      .SLAVE_SELECT_LINE_N_I(sel), .SLAVE_SELECT_LINE_N_O(d_sel),
      .SLAVE_SELECT_LINE_N_OE(d_sel_oe), .MASTER_OUT_DATA_LINE_I(mo),
      .MASTER_OUT_DATA_LINE_O(d_mo), .MASTER_OUT_DATA_LINE_OE(d_mo_oe),
      .MASTER_IN_DATA_LINE_I(mi), .MASTER_IN_DATA_LINE_O(d_mi),
      .MASTER_IN_DATA_LINE_OE(d_mi_oe));
   smsp_peer u_peer (
      .clk(clk_sys), .act_master(peer_m), .phase(cfg.phase), .polarity(cfg.polarity),
      .len(5'(cfg.char_len) + 5'd1), .sclk_i(sck), .sel_n_i(sel), .mosi_i(mo), .miso_i(mi),
      .sclk_o(p_sck), .sel_n_o(p_sel), .dat_o(p_dat), .miso_oe(p_mi_oe));

   // line levels from all enables; a released data line shows its inverse
   assign peer_m = !cfg.master;
   always_comb
   begin
      sck = d_sck_oe ? d_sck : (peer_m ? p_sck : 1'b0);
      sel = d_sel_oe ? d_sel : (peer_m ? p_sel : 1'b1);
      mo = d_mo_oe ? d_mo : (peer_m ? p_dat : mo_f);
      mi = d_mi_oe ? d_mi : (p_mi_oe ? p_dat : mi_f);
   end
   // cycle count, floating levels and frame timing record
   always @(posedge clk_sys)
   begin
      cyc++;
      if (d_mo_oe || peer_m) mo_f <= !mo;
      if (d_mi_oe || p_mi_oe) mi_f <= !mi;
   end
   always @(sck)
      if (sel === 1'b0)
      begin
         if (n_edge < 32) t_e[n_edge] = cyc;
         n_edge++;
      end
   always @(negedge sel)
   begin
      t_lo = cyc;
      n_edge = 0;
   end
   always @(posedge sel) t_hi = cyc;
   always #2 clk_sys = !clk_sys;

   task automatic print_verdict();
      $display("comparisons %0d errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // wait for room, then offer one word for one cycle
   task automatic push(input logic [15:0] w);
      @(negedge clk_sys);
      `WAIT(tx_ready)
      tx_valid = 1'b1;
      tx_data = w;
      @(negedge clk_sys);
      tx_valid = 1'b0;
   endtask

   // take one received word, optionally judging it
   task automatic pop(input logic [15:0] ex, input logic en);
      @(negedge clk_sys);
      `WAIT(rx_valid)
      if (en) `CHK("rx data", ex, rx_data)
      rx_ready = 1'b1;
      @(negedge clk_sys);
      rx_ready = 1'b0;
   endtask

   // one master word against the slave peer, with wire timing judged
   task automatic master_xfer(input logic ph, pol, input logic [6:0] dv, input int n,
                              input logic [15:0] mw, pw);
      int p;
      p = (dv < 7'h03) ? 4 : int'(dv) + 1;
      @(negedge clk_sys);
      cfg = '{1'b1, ph, pol, 1'b1, 4'(n - 1), dv};
      u_peer.tx_word = pw;
      push(mw);
      @(negedge clk_sys);
      `CHK("busy", 1'b1, status[smsp_pkg::ST_BUSY])
      pop(pw, dv > 7'h12);
      `WAIT(sel)
      `CHK("peer rx", mw >> (16 - n), u_peer.rx_word)
      `CHK("edge count", 2 * n, n_edge)
      `CHK("lead", ph ? 2 * p - 3 : p + p / 2 - 3, t_e[0] - t_lo)
      `CHK("first half", ph ? p / 2 : (p + 1) / 2, t_e[1] - t_e[0])
      `CHK("period", p, t_e[2] - t_e[0])
      `CHK("tail", (p + 1) / 2, t_hi - t_e[2 * n - 1])
      `CHK("idle clock", pol, sck)
      $display("master test done: phase %0d polarity %0d divider %0d", ph, pol, dv);
   endtask

   // slave: fill transmit fifo, ignore deselected edges, overrun receive fifo
   task automatic slave_fifo();
      @(negedge clk_sys);
      cfg = '{1'b0, 1'b0, 1'b0, 1'b1, 4'hF, 7'h13};
      for (int i = 0; i < 16; i++) push(16'h1000 + 16'(i));
      `CHK("tx full", 1'b0, tx_ready)
      `CHK("status full", 1'b1, status[smsp_pkg::ST_TX_FULL])
      u_peer.run_master(1'b0, 10);
      `CHK("deselected rx", 1'b0, rx_valid)
      `CHK("deselected drive", 1'b0, d_mi_oe)
      for (int i = 0; i < 17; i++)
      begin
         u_peer.tx_word = 16'hA000 + 16'(i);
         u_peer.run_master(1'b1, 10);
         if (i < 16) `CHK("slave tx", 16'h1000 + 16'(i), u_peer.rx_word)
      end
      `WAIT(status[smsp_pkg::ST_OVERRUN])
      `CHK("overrun", 1'b1, status[smsp_pkg::ST_OVERRUN])
      `CHK("status rx avail", 1'b1, status[smsp_pkg::ST_RX_AVAIL])
      for (int i = 0; i < 16; i++) pop(16'hA000 + 16'(i), 1'b1);
      `CHK("rx empty", 1'b0, rx_valid)
      ovr_clr = 1'b1;
      @(negedge clk_sys);
      ovr_clr = 1'b0;
      @(negedge clk_sys);
      `CHK("status idle", 16'h0000, status)
      $display("slave fifo test done");
   endtask

   // slave with fifos bypassed: one word of room
   task automatic bypass();
      cfg = '{1'b0, 1'b1, 1'b1, 1'b0, 4'hF, 7'h13}; // slave, phase and polarity set
      push(16'h7E81);
      `CHK("bypass full", 1'b0, tx_ready)
      u_peer.tx_word = 16'h3C5A;
      u_peer.run_master(1'b1, 10);
      `CHK("bypass tx", 16'h7E81, u_peer.rx_word)
      pop(16'h3C5A, 1'b1);
      $display("bypass test done");
   endtask

   initial
   begin
      clk_sys = 1'b0;
      rst_b = 1'b0;
      tx_valid = 1'b0;
      rx_ready = 1'b0;
      ovr_clr = 1'b0;
      tx_data = 16'h0000;
      mo_f = 1'b0;
      mi_f = 1'b0;
      cfg = '{1'b1, 1'b0, 1'b0, 1'b1, 4'hF, 7'h13};
      repeat (5) @(negedge clk_sys);
      `CHK("reset status", 16'h0000, status)
      `CHK("reset ready", 1'b1, tx_ready)
      `CHK("reset select", 1'b1, d_sel)
      `CHK("reset clock oe", 1'b1, d_sck_oe)
      repeat (5) @(negedge clk_sys);
      rst_b = 1'b1;
      $display("reset test done");
      master_xfer(1'b0, 1'b0, 7'h14, 16, 16'hC3A5, 16'h5A3C);
      master_xfer(1'b1, 1'b1, 7'h14, 8, 16'h9600, 16'h00B4);
      master_xfer(1'b0, 1'b1, 7'h13, 12, 16'hABC0, 16'h0123);
      master_xfer(1'b1, 1'b0, 7'h13, 2, 16'h8000, 16'h0001);
      master_xfer(1'b0, 1'b0, 7'h02, 4, 16'hA000, 16'h0005);
      slave_fifo();
      bypass();
      print_verdict();
   end
endmodule
